//--- see_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
// Behavioural bus controller, stepping in link ticks
module see_ctrl_model
#(
  parameter int PERIOD_NS = 48
)
(
  input  wire logic sda_i,
  output var logic  scl_o,
  output var logic  pull_o
);
  // Idle bus: clock parked high, data released to the pull-up
  initial
  begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end

  // Four steps make one link clock period; data moves mid-low
  task automatic tick();
    #(PERIOD_NS / 4);
  endtask

  // data moves only while clock is low
  task automatic clock_bit(input logic drive, output logic seen);
    tick();
    pull_o = drive;
    tick();
    scl_o = 1'b1;
    tick();
    seen = sda_i;
    tick();
    scl_o = 1'b0;
  endtask

  // start, also usable as repeated start
  task automatic bus_start();
    tick();
    pull_o = 1'b0;
    tick();
    scl_o = 1'b1;
    tick();
    pull_o = 1'b1;
    tick();
    scl_o = 1'b0;
  endtask

  // stop, leaves the clock parked high
  task automatic bus_stop();
    tick();
    pull_o = 1'b1;
    tick();
    scl_o = 1'b1;
    tick();
    pull_o = 1'b0;
    tick();
  endtask

  // byte out MSB first, ninth clock released for the answer
  task automatic put_byte(input logic [7:0] b, output logic acked);
    logic seen;
    for (int i = 7; i >= 0; i--)
      clock_bit(~b[i], seen);
    clock_bit(1'b0, seen);
    acked = ~seen;
  endtask

  // byte in, then our acknowledge or its absence
  task automatic get_byte(input logic ack_it, output logic [7:0] b);
    logic seen;
    for (int i = 7; i >= 0; i--)
      clock_bit(1'b0, b[i]);
    clock_bit(ack_it, seen);
  endtask

  // nine released clocks, then start and stop
  task automatic recover();
    logic seen;
    for (int i = 0; i < 9; i++)
      clock_bit(1'b0, seen);
    bus_start();
    bus_stop();
  endtask
endmodule
`default_nettype wire

//--- see_eeprom_slave.sv
`timescale 1ns/10ps
`default_nettype none
module see_eeprom_slave
  import see_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYCLES_DFLT,
  parameter logic [3:0]  DEV_TYPE    = DEV_TYPE_DFLT
)
(
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  input  wire logic wp_i,
  output logic      sda_o,
  output logic      sda_oe_n_o,
  output logic      standby_o,
  output logic      busy_o
);

  localparam int TW = $clog2(PROG_CYCLES + 1);

  see_evt_type          ev;
  see_state_type        st_q;
  see_state_type        after_q;
  logic [3:0]           cnt_q;
  logic [DATA_W-1:0]    shift_q;
  logic [ADDR_W-1:0]    addr_q;
  logic [2:0]           page_q;
  logic                 wr_pend_q;
  logic                 busy_q;
  logic [TW-1:0]        timer_q;
  logic                 wp_m1, wp_m2;
  logic                 we_q;
  logic [ADDR_W-1:0]    waddr_q;
  logic [DATA_W-1:0]    wdata_q;
  logic [DATA_W-1:0]    rdata;
  logic                 byte_in;
  logic                 load_rd;
  logic                 go;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Next address within the same page
  function automatic logic [ADDR_W-1:0] page_inc(input logic [ADDR_W-1:0] a);
    page_inc = {a[ADDR_W-1:PAGE_LOW_W], a[PAGE_LOW_W-1:0] + 4'h1};
  endfunction

  // Next address over the whole array, natural wrap to zero
  function automatic logic [ADDR_W-1:0] array_inc(input logic [ADDR_W-1:0] a);
    array_inc = a + 11'h001;
  endfunction

  // ----------------------------------------------------------------
  // Front end and array
  // ----------------------------------------------------------------
  see_link u_link
  (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .scl_i  (scl_i),
    .sda_i  (sda_i),
    .evt_o  (ev)
  );

  see_mem #(.AW(ADDR_W), .DW(DATA_W)) u_mem
  (
    .mclk_i  (mclk_i),
    .we_i    (we_q),
    .waddr_i (waddr_q),
    .wdata_i (wdata_q),
    .raddr_i (addr_q),
    .rdata_o (rdata)
  );

  // Write protect pin synchroniser
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      wp_m1 <= 1'b0;
      wp_m2 <= 1'b0;
    end
    else
    begin
      wp_m1 <= wp_i;
      wp_m2 <= wp_m1;
    end
  end

  // Byte complete on the falling edge after eight bits
  assign byte_in = ev.fall && (cnt_q == BYTE_BITS);
  // Falling edge that must present the next read byte's first bit
  assign load_rd = ev.fall && ((st_q == ST_ACK && after_q == ST_RDATA) || st_q == ST_RNEXT);
  // Protocol decode only when idle of programming and no start or stop
  assign go      = !busy_q && !ev.start && !ev.stop;

  // ----------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------
  // bus ignored while programming
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      st_q       <= ST_IDLE;
      after_q    <= ST_IDLE;
      cnt_q      <= 4'h0;
      shift_q    <= 8'h00;
      addr_q     <= ADDR_RST;
      page_q     <= 3'h0;
      sda_oe_n_o <= 1'b1;
    end
    else if (busy_q)
    begin
      st_q       <= ST_IDLE;
      sda_oe_n_o <= 1'b1;
    end
    else if (ev.start)
    begin
      st_q       <= ST_DEV;
      cnt_q      <= 4'h0;
      sda_oe_n_o <= 1'b1;
    end
    else if (ev.stop)
    begin
      st_q       <= ST_IDLE;
      sda_oe_n_o <= 1'b1;
    end
    else if (load_rd)
    begin
      // counter moves past the byte sent
      // read address wraps over whole array
      st_q       <= ST_RDATA;
      sda_oe_n_o <= rdata[7];
      shift_q    <= {rdata[6:0], 1'b0};
      cnt_q      <= 4'h1;
      addr_q     <= array_inc(addr_q);
    end
    else
    begin
      case (st_q)
        ST_DEV, ST_WADDR, ST_WDATA:
        begin
          if (ev.rise && cnt_q != BYTE_BITS)
          begin
            shift_q <= {shift_q[6:0], ev.sda};
            cnt_q   <= cnt_q + 4'h1;
          end
          else if (byte_in)
          begin
            cnt_q <= 4'h0;
            if (st_q == ST_DEV)
            begin
              if (shift_q[7:4] == DEV_TYPE)
              begin
                page_q     <= shift_q[3:1];
                after_q    <= shift_q[0] ? ST_RDATA : ST_WADDR;
                st_q       <= ST_ACK;
                sda_oe_n_o <= 1'b0;
              end
              else
              begin
                st_q <= ST_IDLE;
              end
            end
            else if (st_q == ST_WADDR)
            begin
              // page bits on top of word address
              addr_q     <= {page_q, shift_q};
              after_q    <= ST_WDATA;
              st_q       <= ST_ACK;
              sda_oe_n_o <= 1'b0;
            end
            else
            begin
              addr_q     <= page_inc(addr_q);
              after_q    <= ST_WDATA;
              st_q       <= ST_ACK;
              sda_oe_n_o <= 1'b0;
            end
          end
        end
        ST_ACK:
        begin
          // acknowledge held one clock then released
          if (ev.fall)
          begin
            st_q       <= after_q;
            sda_oe_n_o <= 1'b1;
          end
        end
        ST_RDATA:
        begin
          if (byte_in)
          begin
            st_q       <= ST_RACK;
            sda_oe_n_o <= 1'b1;
          end
          else if (ev.fall)
          begin
            sda_oe_n_o <= shift_q[7];
            shift_q    <= {shift_q[6:0], 1'b0};
            cnt_q      <= cnt_q + 4'h1;
          end
        end
        ST_RACK:
        begin
          // nak after any byte ends read
          if (ev.rise)
          begin
            st_q <= ev.sda ? ST_IDLE : ST_RNEXT;
          end
        end
        default:
        begin
          st_q <= st_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Array write and program cycle
  // ----------------------------------------------------------------
  // protected array never written
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      we_q    <= 1'b0;
      waddr_q <= ADDR_RST;
      wdata_q <= 8'h00;
    end
    else
    begin
      we_q    <= go && byte_in && st_q == ST_WDATA && !wp_m2;
      waddr_q <= addr_q;
      wdata_q <= shift_q;
    end
  end

  // Bytes wait for a stop before programming is timed
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      wr_pend_q <= 1'b0;
    end
    else if (ev.start || ev.stop || busy_q)
    begin
      wr_pend_q <= 1'b0;
    end
    else if (byte_in && st_q == ST_WDATA && !wp_m2)
    begin
      wr_pend_q <= 1'b1;
    end
  end

  // stop after data starts program cycle
  // polling is refused until the timer ends
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      busy_q  <= 1'b0;
      timer_q <= '0;
    end
    else if (!busy_q && ev.stop && wr_pend_q)
    begin
      busy_q  <= 1'b1;
      timer_q <= TW'(PROG_CYCLES - 1);
    end
    else if (busy_q)
    begin
      if (timer_q == '0)
      begin
        busy_q <= 1'b0;
      end
      else
      begin
        timer_q <= timer_q - 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  // standby once idle and not programming
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      standby_o <= 1'b1;
      busy_o    <= 1'b0;
      sda_o     <= 1'b0;
    end
    else
    begin
      standby_o <= (st_q == ST_IDLE) && !busy_q;
      busy_o    <= busy_q;
      sda_o     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_dev_match;
    st_q == ST_DEV && byte_in && go && shift_q[7:4] == DEV_TYPE;
  endsequence

  sequence s_ack_release;
    (st_q == ST_ACK && !sda_oe_n_o) ##1 (st_q == ST_ACK && !sda_oe_n_o);
  endsequence

  start_enters_dev_a: assert property (ev.start && !busy_q |=> st_q == ST_DEV)
    else $error("start did not open address phase");

  stop_goes_idle_a: assert property (ev.stop |=> st_q == ST_IDLE && sda_oe_n_o)
    else $error("stop did not return to idle");

  match_acks_low_a: assert property (s_dev_match |=> s_ack_release)
    else $error("matching address not acknowledged");

  mismatch_float_a: assert property (st_q == ST_DEV && byte_in && go
                                     && shift_q[7:4] != DEV_TYPE
                                     |=> st_q == ST_IDLE && sda_oe_n_o)
    else $error("mismatched address not released");

  busy_no_ack_a: assert property (busy_q |=> sda_oe_n_o && st_q == ST_IDLE)
    else $error("bus answered while programming");

  page_wrap_a: assert property (we_q |-> addr_q[10:4] == waddr_q[10:4]
                                && addr_q[3:0] == waddr_q[3:0] + 4'h1)
    else $error("page write address left page");

  read_advance_a: assert property (load_rd |=> addr_q == $past(addr_q) + 11'h001)
    else $error("read did not advance counter");

  prog_start_a: assert property (!busy_q && ev.stop && wr_pend_q
                                 |=> busy_q [*8])
    else $error("program cycle not started by stop");

  prog_end_a: assert property (busy_q && timer_q == '0 |=> !busy_q)
    else $error("program cycle length wrong");

  protect_a: assert property (wp_m2 && byte_in && st_q == ST_WDATA |=> !we_q)
    else $error("array written while protected");

  protect_idle_a: assert property (wp_m2 && $past(wp_m2) && ev.stop |=> !busy_q)
    else $error("protected write started program cycle");

  standby_a: assert property (st_q == ST_IDLE && !busy_q |=> standby_o)
    else $error("standby not shown when idle");

endmodule
`default_nettype wire

//--- see_link.sv
`timescale 1ns/10ps
`default_nettype none
module see_link
  import see_pkg::*;
(
  input  wire logic  mclk_i,
  input  wire logic  rst_i,
  input  wire logic  scl_i,
  input  wire logic  sda_i,
  output see_evt_type evt_o
);

  logic       bit_q;
  logic       scl_m1, scl_m2, scl_m3;
  logic       sda_m1, sda_m2, sda_m3;
  logic       bit_m1, bit_m2;
  logic [1:0] rise_q;

  // ----------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------
  // Data bit caught on the serial clock's own rising edge
  always_ff @(posedge scl_i)
  begin
    bit_q <= sda_i;
  end

  // ----------------------------------------------------------------
  // Crossing into the system clock
  // ----------------------------------------------------------------
  // Idle bus reads high, so lines reset high
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      scl_m1 <= 1'b1;
      scl_m2 <= 1'b1;
      scl_m3 <= 1'b1;
      sda_m1 <= 1'b1;
      sda_m2 <= 1'b1;
      sda_m3 <= 1'b1;
    end
    else
    begin
      scl_m1 <= scl_i;
      scl_m2 <= scl_m1;
      scl_m3 <= scl_m2;
      sda_m1 <= sda_i;
      sda_m2 <= sda_m1;
      sda_m3 <= sda_m2;
    end
  end

  // Captured bit is stable for a whole link clock period, two flops settle it
  always_ff @(posedge mclk_i)
  begin
    bit_m1 <= bit_q;
    bit_m2 <= bit_m1;
  end

  // Rising edge delayed so the captured bit has crossed first
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      rise_q <= 2'h0;
    end
    else
    begin
      rise_q <= {rise_q[0], scl_m2 & ~scl_m3};
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      evt_o <= '0;
    end
    else
    begin
      evt_o.start <= scl_m2 & scl_m3 & sda_m3 & ~sda_m2;
      evt_o.stop  <= scl_m2 & scl_m3 & ~sda_m3 & sda_m2;
      evt_o.rise  <= rise_q[1];
      evt_o.fall  <= scl_m3 & ~scl_m2;
      evt_o.sda   <= bit_m2;
    end
  end

endmodule
`default_nettype wire

//--- see_mem.sv
`timescale 1ns/10ps
`default_nettype none
module see_mem
#(
  parameter int AW = 11,
  parameter int DW = 8
)
(
  input  wire logic          mclk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);

  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  // Write port, read data registered
  always_ff @(posedge mclk_i)
  begin
    if (we_i)
    begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_q[raddr_i];
  end

endmodule
`default_nettype wire

//--- see_pkg.sv
`default_nettype none
package see_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int          ADDR_W       = 11;
  localparam int          DATA_W       = 8;
  localparam int          PAGE_LOW_W   = 4;
  localparam logic [3:0]  BYTE_BITS    = 4'h8;
  localparam logic [10:0] ADDR_RST     = 11'h000;

  // Device-type pattern, value is arbitrary
  localparam logic [3:0]  DEV_TYPE_DFLT = 4'h6;

  // ----------------------------------------------------------------
  // Program cycle timing
  // ----------------------------------------------------------------
  localparam int PROG_TIME_MS     = 5;
  localparam int CLK_MHZ          = 200;
  localparam int PROG_CYCLES_DFLT = PROG_TIME_MS * 1000 * CLK_MHZ;

  // ----------------------------------------------------------------
  // Bus events seen in the system clock domain
  // ----------------------------------------------------------------
  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic sda;
  } see_evt_type;

  // Gray codes in declaration order
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_DEV   = 3'h1,
    ST_ACK   = 3'h3,
    ST_WADDR = 3'h2,
    ST_WDATA = 3'h6,
    ST_RDATA = 3'h7,
    ST_RACK  = 3'h5,
    ST_RNEXT = 3'h4
  } see_state_type;

endpackage
`default_nettype wire

//--- testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import see_pkg::*;
  // Short program cycle, still longer than one polling address
  localparam int PROG = 1000;
  typedef struct packed {
    logic [10:0] addr;
    logic [7:0]  data;
  } see_row_type;

  logic        mclk;
  logic        rst;
  logic        wp;
  logic        scl;
  logic        pull;
  logic        sda;
  logic        sda_o;
  logic        sda_oe_n;
  logic        standby;
  logic        busy;
  logic        ack;
  logic [7:0]  rb;
  logic [7:0]  exp_b;
  int          fails;
  int          num_checks;
  see_row_type rows [5] = '{'{11'h000, 8'hA5}, '{11'h001, 8'h3C},
    '{11'h0A0, 8'h96}, '{11'h2B7, 8'h5A}, '{11'h7FF, 8'hC3}};

  // ----------------------------------------------------------------
  // Open-drain line with pull-up
  // ----------------------------------------------------------------
  assign sda = ~(pull | (~sda_oe_n & ~sda_o));

  initial
  begin
    mclk = 1'b0;
  end
  always #2.5 mclk = ~mclk;

  see_ctrl_model u_ctrl (
    .sda_i  (sda),
    .scl_o  (scl),
    .pull_o (pull)
  );

  see_eeprom_slave #(.PROG_CYCLES(PROG), .DEV_TYPE(DEV_TYPE_DFLT)) dut (
    .mclk_i     (mclk),
    .rst_i      (rst),
    .scl_i      (scl),
    .sda_i      (sda),
    .wp_i       (wp),
    .sda_o      (sda_o),
    .sda_oe_n_o (sda_oe_n),
    .standby_o  (standby),
    .busy_o     (busy)
  );

  // ----------------------------------------------------------------
  // Compare and bus helpers
  // ----------------------------------------------------------------
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic wrap_up();
    if (fails == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  function automatic logic [7:0] dev_word(input logic [10:0] a, input logic rd);
    return {DEV_TYPE_DFLT, a[10:8], rd};
  endfunction

  // Device address and word address, no stop
  task automatic set_addr(input logic [10:0] a);
    u_ctrl.bus_start();
    u_ctrl.put_byte(dev_word(a, 1'b0), ack);
    chk_flag(ack, 1'b1, "write address ack");
    u_ctrl.put_byte(a[7:0], ack);
    chk_flag(ack, 1'b1, "word address ack");
  endtask

  task automatic write_run(input logic [10:0] a, input logic [7:0] d0, input int n);
    set_addr(a);
    for (int i = 0; i < n; i++)
    begin
      u_ctrl.put_byte(d0 + 8'(i), ack);
      chk_flag(ack, 1'b1, "data ack");
    end
    u_ctrl.bus_stop();
  endtask

  task automatic rd_start(input logic [10:0] a);
    u_ctrl.bus_start();
    u_ctrl.put_byte(dev_word(a, 1'b1), ack);
    chk_flag(ack, 1'b1, "read address ack");
  endtask

  // Random read of one byte, ended by no-ack and stop
  task automatic read_one(input logic [10:0] a, input logic [7:0] exp);
    set_addr(a);
    rd_start(a);
    u_ctrl.get_byte(1'b0, rb);
    chk_byte(rb, exp, "random read");
    u_ctrl.bus_stop();
  endtask

  // Bounded waits; a lost program cycle shows as busy low
  task automatic wait_prog(input logic exp);
    int n = 0;
    while (busy !== 1'b1 && n < 40)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk_flag(busy, exp, "program cycle started");
    n = 0;
    while (busy !== 1'b0 && n < PROG + 100)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk_flag(busy, 1'b0, "program cycle ended");
    chk_flag(standby, 1'b1, "standby after program");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    fails = 0;
    num_checks = 0;
    rst = 1'b1;
    wp = 1'b0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk_flag(standby, 1'b1, "standby at reset");
    chk_flag(busy, 1'b0, "busy at reset");
    chk_flag(sda_oe_n, 1'b1, "released at reset");
    chk_flag(sda_o, 1'b0, "drive level at reset");
    repeat (4) @(posedge mclk);
    u_ctrl.recover();
    chk_flag(sda_oe_n, 1'b1, "released after recovery");
    // Table: byte write, program cycle, random read back
    foreach (rows[i])
    begin
      write_run(rows[i].addr, rows[i].data, 1);
      wait_prog(1'b1);
      read_one(rows[i].addr, rows[i].data);
    end
    // Seventeen bytes from page offset 14 wrap over the page start
    write_run(11'h12E, 8'h40, 17);
    wait_prog(1'b1);
    set_addr(11'h120);
    rd_start(11'h120);
    for (int j = 0; j < 16; j++)
    begin
      exp_b = (j == 14) ? 8'h50 : (j == 15) ? 8'h41 : 8'h42 + 8'(j);
      u_ctrl.get_byte(j < 15, rb);
      chk_byte(rb, exp_b, "page wrap");
    end
    u_ctrl.bus_stop();
    // Sequential read across the array end, then current address
    set_addr(11'h7FF);
    rd_start(11'h7FF);
    u_ctrl.get_byte(1'b1, rb);
    chk_byte(rb, 8'hC3, "last byte");
    u_ctrl.get_byte(1'b0, rb);
    chk_byte(rb, 8'hA5, "rollover to zero");
    u_ctrl.bus_stop();
    rd_start(11'h001);
    u_ctrl.get_byte(1'b0, rb);
    chk_byte(rb, 8'h3C, "current address");
    u_ctrl.bus_stop();
    // Poll inside the program cycle is ignored, after it answered
    write_run(11'h2B7, 8'h77, 1);
    u_ctrl.bus_start();
    u_ctrl.put_byte(dev_word(11'h2B7, 1'b0), ack);
    chk_flag(ack, 1'b0, "no ack while busy");
    u_ctrl.bus_stop();
    wait_prog(1'b1);
    set_addr(11'h2B7);
    rd_start(11'h2B7);
    u_ctrl.get_byte(1'b0, rb);
    chk_byte(rb, 8'h77, "read after poll");
    u_ctrl.bus_stop();
    // Protected write: full handshake, no change, no program cycle
    @(posedge mclk);
    wp <= 1'b1;
    write_run(11'h0A0, 8'h11, 1);
    wait_prog(1'b0);
    read_one(11'h0A0, 8'h96);
    @(posedge mclk);
    wp <= 1'b0;
    // Wrong type pattern is left unanswered
    u_ctrl.bus_start();
    u_ctrl.put_byte({~DEV_TYPE_DFLT, 3'h0, 1'b0}, ack);
    chk_flag(ack, 1'b0, "type mismatch");
    u_ctrl.bus_stop();
    chk_flag(standby, 1'b1, "standby after mismatch");
    // Mid-run reset clears the counter but keeps the array
    @(posedge mclk);
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk_flag(standby, 1'b1, "standby after second reset");
    chk_flag(sda_oe_n, 1'b1, "released after second reset");
    repeat (4) @(posedge mclk);
    rd_start(11'h000);
    u_ctrl.get_byte(1'b0, rb);
    chk_byte(rb, 8'hA5, "counter after reset");
    u_ctrl.bus_stop();
    wrap_up();
  end

  // Whole run is near 80 us at the 48 ns link clock; give it room
  initial
  begin
    #300_000;
    fails++;
    wrap_up();
  end
endmodule
`default_nettype wire
